// ---- hw/col_limits.sv ----
// Column address counter and upper address limit with APB access.
// Assumes the execution unit drives one instruction per cycle and the
// row counter lives elsewhere; row wrap is signalled in by row_carry.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module col_limits #(
	parameter int MA_W = 32
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rstn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [col_limits_pkg::CWS_W-1:0] column_width_setting,
	input  wire col_limits_pkg::mode_s          mode,
	input  wire col_limits_pkg::instr_s         instr,
	input  wire logic                          row_carry,
	input  wire logic [col_limits_pkg::ROW_W-1:0] row_field,
	input  wire logic [5:0]                    row_width,
	output logic      [MA_W-1:0]               mem_addr,
	output logic                               loop_end
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_q;
	logic rst_n_q;

	// Async assert, synchronous release
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	localparam int CW = col_limits_pkg::COL_W;
	logic [MA_W-1:0]                     upper_limit_field_q;
	logic [CW-1:0]                       column_field_q;
	logic [CW-1:0]                       column_field_d;
	logic [col_limits_pkg::BANK_W-1:0]   final_bank_value_q;
	logic [CW-1:0]                       width_mask;
	logic                                wr_acc;
	logic                                at_bank_end;

	assign wr_acc = psel && penable && pwrite;

	// Mask of used column bits; zero width masks everything
	always_comb begin
		width_mask = '0;
		for (int i = 0; i < CW; i++) begin
			if (i < int'(column_width_setting)) begin
				width_mask[i] = 1'b1;
			end
		end
	end

	assign at_bank_end = (column_field_q == {final_bank_value_q, 1'b0});

	// Upper limit holds only the address width; bits above dropped
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			upper_limit_field_q <= col_limits_pkg::LIMIT_RESET[MA_W-1:0];
		end else if (wr_acc && paddr == col_limits_pkg::LIMIT_OFFS) begin
			upper_limit_field_q <= pwdata[MA_W-1:0];
		end
	end

	// Bank end field
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			final_bank_value_q <= col_limits_pkg::COL_RESET[col_limits_pkg::BANK_W-1:0];
		end else if (wr_acc && paddr == col_limits_pkg::COLUMN_OFFS) begin
			final_bank_value_q <= pwdata[col_limits_pkg::BANK_LSB +: col_limits_pkg::BANK_W];
		end
	end

	// Column next value; software write wins over execution
	always_comb begin
		column_field_d = column_field_q;
		if (wr_acc && paddr == col_limits_pkg::COLUMN_OFFS) begin
			column_field_d = pwdata[col_limits_pkg::COL_LSB +: CW] & width_mask;
		end else if (instr.exec && instr.update_address_flag
				&& column_width_setting != '0) begin
			if (mode.bank_mode_enable) begin
				if (instr.pointer_update_op) begin
					column_field_d = column_field_q;
				end else if (instr.final_loop && !at_bank_end) begin
					column_field_d = (column_field_q - col_limits_pkg::COL_ONE)
						& width_mask;
				end else begin
					column_field_d = column_field_q & width_mask;
				end
			end else if (mode.address_order_select || row_carry) begin
				// Column steps first, or when the row wraps
				if (mode.address_step_direction) begin
					column_field_d = (column_field_q + col_limits_pkg::COL_ONE)
						& width_mask;
				end else begin
					column_field_d = (column_field_q - col_limits_pkg::COL_ONE)
						& width_mask;
				end
			end else begin
				column_field_d = column_field_q & width_mask;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			column_field_q <= col_limits_pkg::COL_RESET[CW-1:0];
		end else begin
			column_field_q <= column_field_d;
		end
	end

	// ----------------------------------------
	// Address forming
	// ----------------------------------------
	logic [MA_W-1:0] addr_d;
	logic [MA_W-1:0] row_part;
	logic [MA_W-1:0] col_part;
	logic [MA_W-1:0] bank_part;
	logic [5:0]      rw;
	logic [5:0]      cw6;

	assign rw  = row_width;
	assign cw6 = {3'h0, column_width_setting};

	// Shift-and-or keeps widths run-time selectable
	always_comb begin
		row_part  = MA_W'(row_field) & ((MA_W'(1) << rw) - MA_W'(1));
		col_part  = MA_W'(column_field_q & width_mask);
		bank_part = MA_W'((column_field_q & width_mask) >> 1);
		addr_d    = row_part;
		if (!mode.bank_mode_enable) begin
			if (column_width_setting != '0) begin
				addr_d = (row_part << cw6) | col_part;
			end
		end else if (column_width_setting > 3'h1) begin
			case (mode.bank_placement_select)
				2'h0:    addr_d = (bank_part << rw) | row_part;
				2'h1:    addr_d = (row_part << (cw6 - 6'h01)) | bank_part;
				2'h2:    addr_d = (bank_part << (rw + cw6 - 6'h01))
					| (row_part << (cw6 - 6'h01)) | bank_part;
				default: addr_d = row_part;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mem_addr <= '0;
		end else begin
			mem_addr <= addr_d;
		end
	end

	// Loop end flag: bank end in bank-mode final loop, else limit reached when incrementing
	always_comb begin
		loop_end = 1'b0;
		if (instr.exec && mode.bank_mode_enable && instr.final_loop) begin
			loop_end = at_bank_end;
		end else if (instr.exec && (instr.plain_loop || instr.final_loop)
				&& mode.address_step_direction) begin
			loop_end = (mem_addr == upper_limit_field_q);
		end
	end

	// ----------------------------------------
	// APB read side
	// ----------------------------------------
	assign pready = 1'b1; // Zero wait states
	assign pslverr = psel && penable && (paddr != col_limits_pkg::LIMIT_OFFS)
		&& (paddr != col_limits_pkg::COLUMN_OFFS) && (paddr != col_limits_pkg::STATUS_OFFS);

	always_comb begin
		prdata = '0;
		case (paddr)
			col_limits_pkg::LIMIT_OFFS:  prdata = 32'(upper_limit_field_q);
			col_limits_pkg::COLUMN_OFFS: prdata = 32'({final_bank_value_q, 11'h000,
				column_field_q});
			col_limits_pkg::STATUS_OFFS: prdata = 32'(mem_addr);
			default:                     prdata = '0;
		endcase
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Column write as the bus completes it
	sequence s_col_write;
		wr_acc && paddr == col_limits_pkg::COLUMN_OFFS;
	endsequence

	// Limit write as the bus completes it
	sequence s_limit_write;
		wr_acc && paddr == col_limits_pkg::LIMIT_OFFS;
	endsequence

	// Executed update outside bank mode with a usable column width
	sequence s_flat_update;
		instr.exec && instr.update_address_flag && !wr_acc
			&& column_width_setting != '0 && !mode.bank_mode_enable;
	endsequence

	// Column moves up: column first, or the row counter wrapped
	sequence s_col_up;
		s_flat_update ##0 ((mode.address_order_select || row_carry)
			&& mode.address_step_direction);
	endsequence

	// Column moves down under the same ordering
	sequence s_col_down;
		s_flat_update ##0 ((mode.address_order_select || row_carry)
			&& !mode.address_step_direction);
	endsequence

	// Row first and no wrap: column only loses its high bits
	sequence s_col_wait;
		s_flat_update ##0 (!mode.address_order_select && !row_carry);
	endsequence

	// Final loop in bank mode sitting on the bank end
	sequence s_bank_last;
		instr.exec && instr.final_loop && mode.bank_mode_enable && at_bank_end;
	endsequence

	// Column register behaviour
	a_zero_width_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(column_width_setting == '0 && !(wr_acc && paddr == col_limits_pkg::COLUMN_OFFS))
		|=> column_field_q == $past(column_field_q))
		else $error("column moved with zero width");
	a_write_masked: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		s_col_write
		|=> column_field_q == ($past(pwdata[CW-1:0]) & $past(width_mask)))
		else $error("column write not masked");
	a_pup_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(instr.exec && instr.pointer_update_op && mode.bank_mode_enable && !wr_acc)
		|=> column_field_q == $past(column_field_q))
		else $error("pointer update changed column");
	a_bank_dec: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(instr.exec && instr.final_loop && mode.bank_mode_enable && !at_bank_end
		&& instr.update_address_flag && !instr.pointer_update_op && !wr_acc
		&& column_width_setting != '0)
		|=> column_field_q == (($past(column_field_q) - 5'h01) & $past(width_mask)))
		else $error("final loop did not decrement");
	a_bank_stop: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(s_bank_last ##0 !wr_acc)
		|=> column_field_q == $past(column_field_q & width_mask))
		else $error("decrement past bank end");
	a_update_mask: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(instr.exec && instr.update_address_flag && !wr_acc && column_width_setting != '0
		&& !(mode.bank_mode_enable && instr.pointer_update_op))
		|=> (column_field_q & ~$past(width_mask)) == '0)
		else $error("high column bits kept");
	a_step_up: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		s_col_up
		|=> column_field_q == (($past(column_field_q) + 5'h01) & $past(width_mask)))
		else $error("column did not step up");
	a_step_down: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		s_col_down
		|=> column_field_q == (($past(column_field_q) - 5'h01) & $past(width_mask)))
		else $error("column did not step down");
	a_row_first_wait: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		s_col_wait
		|=> column_field_q == $past(column_field_q & width_mask))
		else $error("column moved before row wrap");
	a_bank_keep: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(instr.exec && instr.update_address_flag && mode.bank_mode_enable && !wr_acc
		&& !instr.final_loop && !instr.pointer_update_op && column_width_setting != '0)
		|=> column_field_q == $past(column_field_q & width_mask))
		else $error("bank mode update not masked");

	// Limit register and loop end
	a_limit_write: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		s_limit_write
		|=> upper_limit_field_q == $past(pwdata[MA_W-1:0]))
		else $error("limit write lost");
	a_limit_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		!(wr_acc && paddr == col_limits_pkg::LIMIT_OFFS)
		|=> $stable(upper_limit_field_q))
		else $error("limit changed without write");
	a_limit_end: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(instr.exec && instr.plain_loop && !mode.bank_mode_enable
		&& mode.address_step_direction && mem_addr == upper_limit_field_q) |-> loop_end)
		else $error("limit not detected");
	a_bank_end_flag: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		s_bank_last |-> loop_end)
		else $error("bank end not flagged");

	// Address forming
	a_row_col_addr: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(!mode.bank_mode_enable && column_width_setting == '0)
		|=> mem_addr == $past(row_part))
		else $error("address not row only");

endmodule

`default_nettype wire

// ---- hw/col_limits_pkg.sv ----
// Constants and carriers for the column address and upper limit block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package col_limits_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] LIMIT_OFFS  = 12'h000;
	localparam logic [11:0] COLUMN_OFFS = 12'h004;
	localparam logic [11:0] STATUS_OFFS = 12'h008;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int COL_LSB   = 0;
	localparam int COL_W     = 5;
	localparam int BANK_LSB  = 16;
	localparam int BANK_W    = 4;
	localparam int CWS_W     = 3;
	localparam int ROW_W     = 32;
	localparam logic [COL_W-1:0] COL_ONE = 5'h01;
	localparam logic [31:0] COL_RESET    = 32'h0000_0000;
	localparam logic [31:0] LIMIT_RESET  = 32'h0000_0000;

	// ----------------------------------------
	// Instruction carrier
	// ----------------------------------------
	typedef struct packed {
		logic exec;        // One instruction executes this cycle
		logic update_address_flag;
		logic final_loop;  // Final-loop operation
		logic pointer_update_op;
		logic plain_loop;  // Other loop operation
	} instr_s;

	typedef struct packed {
		logic bank_mode_enable;
		logic [1:0] bank_placement_select;
		logic address_step_direction; // 1 = increment
		logic address_order_select;   // 1 = column first
	} mode_s;

endpackage

// ---- verification/mem_array_model.sv ----
// Memory array stand-in: captures every address the block presents.
// Assumes the address is registered in the block and stable between edges.
`timescale 1ns/1ps
`default_nettype none

module mem_array_model (
	input  wire logic        ref_clk,
	input  wire logic [31:0] addr,
	output logic      [31:0] seen_q
);
	// ------------------------------
	// Capture
	// ------------------------------
	// Sampled one edge late, so the bench sees what the array was given
	always_ff @(posedge ref_clk) begin
		seen_q <= addr;
	end
endmodule

`default_nettype wire

// ---- verification/tb_mbist_column_address_limits.sv ----
// Self-checking bench for the column counter and upper limit block.
// Assumes zero-wait APB and an idle instruction port during bus cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_mbist_column_address_limits;
	logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, mem_addr, seen, rd;
	logic pready, pslverr, loop_end, er, row_carry = 1'b0;
	logic [2:0] cws = 3'h0;
	logic [4:0] mode = 5'h03, instr = 5'h00;
	logic [31:0] row_field = 32'h3;
	logic [5:0] row_width = 6'h02;
	int error_cnt = 0, comparisons = 0;

	col_limits #(.MA_W(32)) DUT (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.column_width_setting(cws), .mode(mode), .instr(instr), .row_carry(row_carry),
		.row_field(row_field), .row_width(row_width), .mem_addr(mem_addr),
		.loop_end(loop_end));
	mem_array_model mem (.ref_clk(ref_clk), .addr(mem_addr), .seen_q(seen));

	// 25 MHz clock
	always #20 ref_clk = ~ref_clk;

	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk) begin psel <= 1'b1; penable <= 1'b0; pwrite <= w; end
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk) penable <= 1'b1;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50) error_cnt++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One instruction pulse; loop_end sampled in its own cycle
	task automatic run(input logic [4:0] op);
		@(posedge ref_clk) instr <= op;
		@(posedge ref_clk) instr <= 5'h00;
		er = loop_end;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic close_out;
		$display("Checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_regs;
		cws <= 3'h3;
		apb(1'b1, 12'h004, 32'hFFFF_FFFF); apb(1'b0, 12'h004, 0); chk(rd, 32'h000F_0007);
		apb(1'b1, 12'h000, 32'h1234_5678); apb(1'b0, 12'h000, 0); chk(rd, 32'h1234_5678);
		apb(1'b1, 12'h00C, 32'h5); chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h00C, 0); chk(rd, 32'h0);
		cws <= 3'h0;
		apb(1'b1, 12'h004, 32'h0000_001F); apb(1'b0, 12'h004, 0); chk(rd, 32'h0);
		run(5'h18); apb(1'b0, 12'h004, 0); chk(rd, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_step;
		cws <= 3'h5;
		apb(1'b1, 12'h004, 32'h0000_0005);
		cws <= 3'h2;
		run(5'h18); apb(1'b0, 12'h004, 0); chk(rd, 32'h0000_0002);
		cws <= 3'h3;
		apb(1'b1, 12'h004, 32'h0000_0002);
		run(5'h18); apb(1'b0, 12'h004, 0); chk(rd, 32'h0000_0003);
		run(5'h10); apb(1'b0, 12'h004, 0); chk(rd, 32'h0000_0003);
		$display("test step done");
	endtask
	task automatic t_addr;
		apb(1'b1, 12'h004, 32'h0000_0005);
		repeat (3) @(posedge ref_clk);
		chk(mem_addr, 32'h0000_001D);
		chk(seen, 32'h0000_001D);
		apb(1'b1, 12'h000, 32'h0000_001D);
		run(5'h11); chk({31'h0, er}, 32'h1);
		apb(1'b1, 12'h000, 32'h0000_0040);
		run(5'h11); chk({31'h0, er}, 32'h0);
		$display("test addr done");
	endtask
	task automatic t_bank;
		mode <= 5'h12;
		apb(1'b1, 12'h004, 32'h0001_0007);
		repeat (3) @(posedge ref_clk);
		chk(mem_addr, 32'h0000_000F);
		run(5'h1C); chk({31'h0, er}, 32'h0);
		apb(1'b0, 12'h004, 0); chk(rd, 32'h0001_0006);
		apb(1'b1, 12'h004, 32'h0001_0002);
		run(5'h1C); chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h004, 0); chk(rd, 32'h0001_0002);
		apb(1'b1, 12'h004, 32'h0001_0005);
		run(5'h1A); apb(1'b0, 12'h004, 0); chk(rd, 32'h0001_0005);
		mode <= 5'h03;
		$display("test bank done");
	endtask
	task automatic t_order;
		mode <= 5'h01;
		apb(1'b1, 12'h004, 32'h0000_0000);
		run(5'h18); apb(1'b0, 12'h004, 0); chk(rd, 32'h0000_0007);
		mode <= 5'h02;
		apb(1'b1, 12'h004, 32'h0000_0003);
		run(5'h18); apb(1'b0, 12'h004, 0); chk(rd, 32'h0000_0003);
		row_carry <= 1'b1;
		run(5'h18);
		row_carry <= 1'b0;
		apb(1'b0, 12'h004, 0); chk(rd, 32'h0000_0004);
		mode <= 5'h16;
		apb(1'b1, 12'h004, 32'h0000_0005);
		repeat (3) @(posedge ref_clk);
		chk(mem_addr, 32'h0000_000E);
		mode <= 5'h1A;
		repeat (3) @(posedge ref_clk);
		chk(mem_addr, 32'h0000_002E);
		mode <= 5'h03;
		$display("test order done");
	endtask

	// Watchdog sized well above the expected run
	initial begin
		#200us;
		error_cnt++;
		close_out();
	end

	// Main sequence; registers initialised before any instruction runs
	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		apb(1'b1, 12'h000, 32'h0);
		t_regs();
		t_step();
		t_addr();
		t_bank();
		t_order();
		close_out();
	end
endmodule

`default_nettype wire
